// ---- rtl/tpo_top.v ----
// time pulse output gating: time base choice, holdover timer and apb registers
// assumes time pulses and sync status come from logic on the same clock
`timescale 1ns/1ps
`include "tpo_defs.vh"
module tpo_top #(
   parameter [39:0] MINUTE_CYCLES = `TPO_MINUTE_CYCLES,
   parameter [11:0] CARRIER_HALF = `TPO_CARRIER_HALF
) (
   input wire clk,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // system state
   input wire time_valid,
   input wire sync_radio,
   input wire pulse_local,
   input wire pulse_standard,
   input wire pulse_utc,
   // outputs
   output reg primary_pulse_output,
   output reg secondary_pulse_output,
   output wire antenna_simulation_output,
   output wire antenna_simulation_low
);
   reg [7:0] pri_conf_q;
   reg [7:0] sec_conf_q;
   reg [7:0] hold_lim_q;
   reg sec_en_q;
   reg [7:0] remain_q;
   reg radio_q;
   reg [31:0] rdata_d;
   reg rerr_d;
   reg hit_d;
   wire [7:0] wbyte;
   wire setup_acc;
   wire wr_done;
   wire minute_tick;
   wire hold_start;
   wire gate_open;
   wire pri_sel;
   wire sec_sel;
   reg [2:0] state_q;
   reg [2:0] state_d;

   // holdover states, one-hot
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_LAPSED = 3'b100;

   // pick the pulse stream matching a config byte's time base field
   function pick_pulse;
      input [7:0] conf;
      input p_loc;
      input p_std;
      input p_utc;
      begin
         case (conf[`TPO_TB_MSB:`TPO_TB_LSB])
            `TPO_TB_STANDARD: pick_pulse = p_std;
            `TPO_TB_UTC: pick_pulse = p_utc;
            `TPO_TB_SPARE: pick_pulse = p_loc;
            default: pick_pulse = p_loc;
         endcase
      end
   endfunction

   // keep a written limit inside the legal span
   function [7:0] clamp_limit;
      input [7:0] v;
      begin
         if (v < `TPO_HOLD_MIN) begin
            clamp_limit = `TPO_HOLD_MIN;
         end else begin
            clamp_limit = v;
         end
      end
   endfunction

   // apb: first access cycle prepares the answer, second completes it,
   // so read data and pready leave flip-flops directly
   assign setup_acc = psel & penable & ~pready;
   assign wr_done = psel & penable & pready & pwrite & ~pslverr;
   assign wbyte = pwdata[7:0];

   always @* begin
      rdata_d = 32'h00000000;
      hit_d = 1'b1;
      case (paddr)
         `TPO_ADDR_PRI_CONF: rdata_d[7:0] = pri_conf_q;
         `TPO_ADDR_SEC_CONF: rdata_d[7:0] = sec_conf_q;
         `TPO_ADDR_HOLD_LIM: rdata_d[7:0] = hold_lim_q;
         `TPO_ADDR_CTRL: rdata_d[`TPO_CTRL_SEC_EN] = sec_en_q;
         `TPO_ADDR_STATUS: begin
            rdata_d[`TPO_ST_VALID] = time_valid;
            rdata_d[`TPO_ST_RADIO] = radio_q;
            rdata_d[`TPO_ST_ACTIVE] = state_q[1];
            rdata_d[`TPO_ST_LAPSED] = state_q[2];
            rdata_d[`TPO_ST_GATE] = gate_open;
            rdata_d[`TPO_ST_REM_MSB:`TPO_ST_REM_LSB] = remain_q;
         end
         default: hit_d = 1'b0;
      endcase
      // status is read only; writing it is refused
      rerr_d = ~hit_d | (pwrite & (paddr == `TPO_ADDR_STATUS));
   end

   always @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_acc;
         if (setup_acc) begin
            prdata <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= rerr_d;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // configuration registers
   always @(posedge clk) begin
      if (rst) begin
         pri_conf_q <= `TPO_CONF_RESET;
         sec_conf_q <= `TPO_CONF_RESET;
         hold_lim_q <= `TPO_HOLD_DEFAULT;
         sec_en_q <= 1'b0;
      end else if (wr_done) begin
         case (paddr)
            `TPO_ADDR_PRI_CONF: pri_conf_q <= wbyte;
            `TPO_ADDR_SEC_CONF: sec_conf_q <= wbyte;
            `TPO_ADDR_HOLD_LIM: hold_lim_q <= clamp_limit(wbyte);
            `TPO_ADDR_CTRL: sec_en_q <= pwdata[`TPO_CTRL_SEC_EN];
            default: sec_en_q <= sec_en_q;
         endcase
      end
   end

   // holdover timer shared by both pulses
   assign hold_start = radio_q & ~sync_radio & time_valid;

   tpo_prescale #(
      .WIDTH(40),
      .PERIOD(MINUTE_CYCLES)
   ) u_minute (
      .clk(clk),
      .rst(rst),
      .clr(hold_start),
      .tick_q(minute_tick)
   );

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (hold_start) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (sync_radio) begin
               state_d = ST_IDLE;
            end else if (minute_tick && remain_q == 8'h01 && hold_lim_q != `TPO_HOLD_MAX) begin
               state_d = ST_LAPSED;
            end
         end
         ST_LAPSED: begin
            if (sync_radio) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         remain_q <= 8'h00;
         radio_q <= 1'b0;
      end else begin
         state_q <= state_d;
         radio_q <= sync_radio;
         if (hold_start && state_q == ST_IDLE) begin
            remain_q <= hold_lim_q;
         end else if (sync_radio) begin
            remain_q <= 8'h00;
         end else if (state_q == ST_RUN && minute_tick && remain_q != 8'h00
                      && hold_lim_q != `TPO_HOLD_MAX) begin
            remain_q <= remain_q - 8'h01;
         end
      end
   end

   // one gate for every output; limit 255 never closes it
   assign gate_open = time_valid & ((hold_lim_q == `TPO_HOLD_MAX) | (state_q != ST_LAPSED));
   assign pri_sel = pick_pulse(pri_conf_q, pulse_local, pulse_standard, pulse_utc);
   assign sec_sel = pick_pulse(sec_conf_q, pulse_local, pulse_standard, pulse_utc);

   always @(posedge clk) begin
      if (rst) begin
         primary_pulse_output <= 1'b0;
         secondary_pulse_output <= 1'b0;
      end else begin
         primary_pulse_output <= gate_open & pri_sel;
         secondary_pulse_output <= gate_open & sec_en_q & sec_sel;
      end
   end

   // the antenna simulation is keyed from the same primary pulse
   tpo_carrier #(
      .WIDTH(12),
      .HALF(CARRIER_HALF)
   ) u_carrier (
      .clk(clk),
      .rst(rst),
      .run(gate_open),
      .key_low(pri_sel),
      .carrier_q(antenna_simulation_output),
      .low_q(antenna_simulation_low)
   );
endmodule // tpo_top

// ---- rtl/tpo_defs.vh ----
// constants for the time pulse output gating block
// assumes a 100 MHz system clock and a 32-bit apb register bus
`ifndef TPO_DEFS_VH
`define TPO_DEFS_VH

// clock rate and derived timing
`define TPO_CLK_HZ 64'd100000000
`define TPO_MINUTE_S 64'd60
`define TPO_CARRIER_HZ 64'd77500
// one minute and half a carrier period in clock cycles; the half period is
// rounded to whole cycles, so the simulated carrier runs about 0.03 % fast
`define TPO_MINUTE_CYCLES 40'd6000000000
`define TPO_CARRIER_HALF 12'd645

// register byte addresses
`define TPO_ADDR_PRI_CONF 12'h000
`define TPO_ADDR_SEC_CONF 12'h004
`define TPO_ADDR_HOLD_LIM 12'h008
`define TPO_ADDR_CTRL 12'h00c
`define TPO_ADDR_STATUS 12'h010

// configuration byte fields
`define TPO_TB_MSB 7
`define TPO_TB_LSB 6
`define TPO_TB_LOCAL 2'h0
`define TPO_TB_STANDARD 2'h1
`define TPO_TB_UTC 2'h2
`define TPO_TB_SPARE 2'h3
`define TPO_CONF_RESET 8'h00

// holdover limit in minutes
`define TPO_HOLD_MIN 8'h02
`define TPO_HOLD_MAX 8'hff
`define TPO_HOLD_DEFAULT 8'h37

// control and status bit positions
`define TPO_CTRL_SEC_EN 0
`define TPO_ST_VALID 0
`define TPO_ST_RADIO 1
`define TPO_ST_ACTIVE 2
`define TPO_ST_LAPSED 3
`define TPO_ST_GATE 4
`define TPO_ST_REM_LSB 8
`define TPO_ST_REM_MSB 15

`endif

// ---- rtl/tpo_prescale.v ----
// periodic tick generator: one pulse every PERIOD cycles
// assumes clr restarts the count so that the first tick follows a full period
`timescale 1ns/1ps
module tpo_prescale #(
   parameter WIDTH = 40,
   parameter [WIDTH-1:0] PERIOD = 40'd6000000000
) (
   input wire clk,
   input wire rst,
   input wire clr,
   output reg tick_q
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge clk) begin
      if (rst || clr) begin
         cnt_q <= {WIDTH{1'b0}};
         tick_q <= 1'b0;
      end else if (cnt_q == PERIOD - {{(WIDTH-1){1'b0}}, 1'b1}) begin
         cnt_q <= {WIDTH{1'b0}};
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end
endmodule // tpo_prescale

// ---- rtl/tpo_carrier.v ----
// square carrier for the antenna simulation, keyed low while the pulse is active
// assumes HALF is the half period in clock cycles; the rate is rounded to whole cycles
`timescale 1ns/1ps
module tpo_carrier #(
   parameter WIDTH = 12,
   parameter [WIDTH-1:0] HALF = 12'd645
) (
   input wire clk,
   input wire rst,
   input wire run,
   input wire key_low,
   output reg carrier_q,
   output reg low_q
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge clk) begin
      if (rst || !run) begin
         cnt_q <= {WIDTH{1'b0}};
         carrier_q <= 1'b0;
         low_q <= 1'b0;
      end else begin
         // amplitude drop follows the pulse; carrier phase never stops while running
         low_q <= key_low;
         if (cnt_q == HALF - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            cnt_q <= {WIDTH{1'b0}};
            carrier_q <= ~carrier_q;
         end else begin
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // tpo_carrier

// ---- bench/tpo_board_model.sv ----
// partner model: a board that counts rising edges of the signal it receives
// assumes the signal comes from the same clock domain
`timescale 1ns/1ps
module tpo_board_model (
   input wire clk,
   input wire rst,
   input wire pulse_in,
   output reg [15:0] edges_q
);
   reg last_q;
   always @(posedge clk) begin
      last_q <= pulse_in;
      if (rst)
         edges_q <= 16'h0;
      else if (pulse_in && !last_q)
         edges_q <= edges_q + 16'h1;
   end
endmodule // tpo_board_model

// ---- bench/tpo_top_chk.sv ----
// assertions on the top ports of the pulse gating block
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module tpo_top_chk (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire time_valid,
   input wire sync_radio,
   input wire pulse_local,
   input wire pulse_standard,
   input wire pulse_utc,
   input wire primary_pulse_output,
   input wire secondary_pulse_output,
   input wire antenna_simulation_output,
   input wire antenna_simulation_low
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire any_p = pulse_local | pulse_standard | pulse_utc;
   wire all_p = pulse_local & pulse_standard & pulse_utc;
   property p_ready; psel && penable && !pready |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("late ready");
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("ready too long");
   property p_gate; !time_valid |=> !primary_pulse_output && !secondary_pulse_output; endproperty
   a_gate: assert property (p_gate) else $error("pulse without valid time");
   property p_ant; (!time_valid)[*4] |-> !antenna_simulation_output && !antenna_simulation_low; endproperty
   a_ant: assert property (p_ant) else $error("carrier without valid time");
   property p_pri; primary_pulse_output |-> $past(any_p); endproperty
   a_pri: assert property (p_pri) else $error("primary with no source");
   property p_sec; secondary_pulse_output |-> $past(any_p); endproperty
   a_sec: assert property (p_sec) else $error("secondary with no source");
   property p_low; antenna_simulation_low |-> $past(any_p); endproperty
   a_low: assert property (p_low) else $error("drop with no pulse");
   property p_on; (time_valid && sync_radio)[*3] ##0 all_p |=> primary_pulse_output; endproperty
   a_on: assert property (p_on) else $error("pulse gated in radio");
endmodule // tpo_top_chk
bind tpo_top tpo_top_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
   .time_valid(time_valid), .sync_radio(sync_radio), .pulse_local(pulse_local), .pulse_standard(pulse_standard),
   .pulse_utc(pulse_utc), .primary_pulse_output(primary_pulse_output),
   .secondary_pulse_output(secondary_pulse_output), .antenna_simulation_output(antenna_simulation_output),
   .antenna_simulation_low(antenna_simulation_low));

// ---- bench/time_pulse_output_gating_test.sv ----
// self-checking bench for the pulse gating block
// assumes short minute and carrier counts so holdover fits the run
`timescale 1ns/1ps
module time_pulse_output_gating_test;
   reg clk, rst, psel, penable, pwrite, tv, radio, e;
   reg [11:0] paddr;
   reg [31:0] pwdata, rdv;
   reg [2:0] pls;
   reg [1:0] code;
   reg [5:0] junk;
   reg [15:0] snap;
   wire [31:0] prdata;
   wire pready, pslverr, pri, sec, ant, drop;
   wire [15:0] edges;
   integer fail_count, tests_run, seed, c, i;
   tpo_top #(.MINUTE_CYCLES(40'd20), .CARRIER_HALF(12'd4)) uut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .time_valid(tv), .sync_radio(radio), .pulse_local(pls[0]), .pulse_standard(pls[1]),
      .pulse_utc(pls[2]), .primary_pulse_output(pri), .secondary_pulse_output(sec),
      .antenna_simulation_output(ant), .antenna_simulation_low(drop));
   tpo_board_model board (.clk(clk), .rst(rst), .pulse_in(ant), .edges_q(edges));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task print_verdict;
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count = fail_count + 1;
         print_verdict;
      end
      rdv = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function sel(input [1:0] cd, input [2:0] p);
      sel = cd == 2'h1 ? p[1] : cd == 2'h2 ? p[2] : p[0];
   endfunction
   task wt(input integer k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   initial begin
      seed = 32'hb223;
      fail_count = 0;
      tests_run = 0;
      {rst, tv, radio} = 3'h7;
      {psel, penable, pwrite, paddr, pwdata, pls} = 0;
      repeat (3) @(posedge clk);
      rst <= 0;
      apb(0, 12'h008, 0);
      chk(rdv, 32'h37);
      apb(1, 12'h008, 1);
      apb(0, 12'h008, 0);
      chk(rdv, 32'h2);
      apb(1, 12'h010, 0);
      chk(32'(e), 1);
      apb(0, 12'h020, 0);
      chk(32'(e), 1);
      for (c = 0; c < 4; c = c + 1) begin
         code = c[1:0];
         junk = $random(seed);
         apb(1, 12'h000, {24'h0, code, junk});
         apb(1, 12'h004, {24'h0, code ^ 2'h1, junk});
         apb(1, 12'h00c, {31'h0, code != 2'h0});
         for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            pls <= $random(seed);
            wt(1);
            chk(32'(pri), 32'(sel(code, pls)));
            chk(32'(drop), 32'(sel(code, pls)));
            chk(32'(sec), 32'((code != 2'h0) & sel(code ^ 2'h1, pls)));
         end
      end
      @(posedge clk);
      pls <= 3'h7;
      apb(1, 12'h008, 3);
      @(posedge clk);
      radio <= 0;
      wt(40);
      snap = edges;
      chk(32'({pri, sec}), 3);
      wt(16);
      chk(32'(edges - snap >= 16'h2), 1);
      wt(14);
      chk(32'({pri, sec, ant}), 0);
      snap = edges;
      wt(16);
      chk(32'(edges), 32'(snap));
      // status while lapsed: time valid, lapsed, gate shut, nothing left
      apb(0, 12'h010, 0);
      chk(rdv, 32'h9);
      @(posedge clk);
      radio <= 1;
      wt(3);
      chk(32'(pri), 1);
      apb(1, 12'h008, 255);
      @(posedge clk);
      radio <= 0;
      // longer than 255 shortened minutes, so a counting timer would have lapsed
      wt(5200);
      chk(32'(pri), 1);
      apb(0, 12'h010, 0);
      chk(rdv, 32'hff15);
      @(posedge clk);
      tv <= 0;
      wt(5);
      chk(32'({pri, ant}), 0);
      print_verdict;
   end
endmodule // time_pulse_output_gating_test
